// ---- cache_tag_regs.vh ----
// Constants for the set-associative cache tag lookup
`ifndef CACHE_TAG_REGS_VH
`define CACHE_TAG_REGS_VH
`define ADDR_W        20
`define WORD_W        2
`define SET_W         9
`define TAG_W         9
`define DATA_W        8
`define WAYS          2
`define WORDS_PER_BLK 4
`define STEP_NS       100
`define CLK_NS        25
`define STEP_CYC      (`STEP_NS / `CLK_NS)
`define POL_FIFO      2'h0
`define POL_LRU       2'h1
`define POL_RAND      2'h2
`define INVALID_TAG   9'h100
`endif

// ---- tag_way.v ----
// One buffer-and-tag group with its own comparator
`timescale 1ns/100ps
`include "cache_tag_regs.vh"
module tag_way
(
	input  wire                 clk_i,
	input  wire                 arst_n_i,
	input  wire                 clr_i,
	input  wire [`SET_W-1:0]    set_i,
	input  wire [`TAG_W-2:0]    tag_i,
	input  wire [`WORD_W-1:0]   word_i,
	input  wire                 wr_tag_i,
	input  wire                 wr_dat_i,
	input  wire [`WORD_W-1:0]   wr_word_i,
	input  wire [`DATA_W-1:0]   wr_data_i,
	input  wire [`SET_W-1:0]    clr_set_i,
	output wire                 hit_o,
	output wire [`DATA_W-1:0]   data_o
);
	localparam SETS = 1 << `SET_W;
	reg [`TAG_W-1:0]  tag_mem [0:SETS-1];
	reg [`DATA_W-1:0] dat_mem [0:SETS*`WORDS_PER_BLK-1];

	// Tag store: one entry per block, invalid code on clear
	always @(posedge clk_i)
	begin
		if (clr_i)
			tag_mem[clr_set_i] <= `INVALID_TAG;
		else if (wr_tag_i)
			tag_mem[set_i] <= {1'b0, tag_i};
	end

	// Data buffer, written word by word during a fill
	always @(posedge clk_i)
	begin
		if (wr_dat_i)
			dat_mem[{set_i, wr_word_i}] <= wr_data_i;
	end

	// Combinational compare; invalid code has top bit set
	assign hit_o  = (tag_mem[set_i] == {1'b0, tag_i});
	assign data_o = dat_mem[{set_i, word_i}];
endmodule // tag_way

// ---- cache_tag_lookup.v ----
// Cache tag lookup and hit/miss control top
`timescale 1ns/100ps
`include "cache_tag_regs.vh"
module cache_tag_lookup
(
	input  wire                 clk_i,
	input  wire                 arst_n_i,
	input  wire                 req_i,
	input  wire [`ADDR_W-1:0]   addr_i,
	input  wire [1:0]           policy_i,
	input  wire                 mem_ack_i,
	input  wire [`DATA_W-1:0]   mem_data_i,
	output reg                  hit_o,
	output reg                  miss_o,
	output reg                  wait_o,
	output reg                  ack_o,
	output reg  [`DATA_W-1:0]   rdata_o,
	output reg                  mem_req_o,
	output reg  [`ADDR_W-1:0]   mem_addr_o,
	output reg                  ready_o
);
	localparam S_CLR  = 2'h0;
	localparam S_IDLE = 2'h1;
	localparam S_FILL = 2'h2;
	localparam SETS   = 1 << `SET_W;

	reg  [1:0]          state_q;
	reg  [`SET_W-1:0]   clr_q;
	reg  [`ADDR_W-1:0]  addr_q;
	reg  [`WORD_W-1:0]  cnt_q;
	reg                 victim_q;
	reg  [SETS-1:0]     fifo_q;
	reg  [SETS-1:0]     lru_q;
	reg  [7:0]          lfsr_q;
	reg  [`DATA_W-1:0]  crit_q;

	wire                idle = (state_q == S_IDLE);
	wire [`ADDR_W-1:0]  la = idle ? addr_i : addr_q;
	wire [`SET_W-1:0]   set = la[`WORD_W +: `SET_W];
	wire [`TAG_W-2:0]   tag = la[`ADDR_W-1 -: `TAG_W-1];
	wire [`WAYS-1:0]    hit_w;
	wire [`DATA_W-1:0]  dat_w [0:`WAYS-1];
	wire                any_hit = |hit_w;
	wire                hit_way = hit_w[1];
	wire                fill_wr = (state_q == S_FILL) && mem_ack_i;
	wire [`SET_W-1:0]   aset = addr_q[`WORD_W +: `SET_W];

	// Replacement choice from selected policy
	function pick;
		input [1:0] pol;
		input       f;
		input       l;
		input       r;
		begin
			if (pol == `POL_LRU)
				pick = ~l;
			else if (pol == `POL_RAND)
				pick = r;
			else
				pick = f;
		end
	endfunction

	// Groups each compare the same set index
	genvar g;
	generate
		for (g = 0; g < `WAYS; g = g + 1)
		begin : way
			tag_way u_way
			(
				.clk_i     (clk_i),
				.arst_n_i  (arst_n_i),
				.clr_i     (state_q == S_CLR),
				.set_i     (set),
				.tag_i     (tag),
				.word_i    (la[`WORD_W-1:0]),
				.wr_tag_i  (fill_wr && (cnt_q == 2'h3) && (victim_q == g)),
				.wr_dat_i  (fill_wr && (victim_q == g)),
				.wr_word_i (cnt_q),
				.wr_data_i (mem_data_i),
				.clr_set_i (clr_q),
				.hit_o     (hit_w[g]),
				.data_o    (dat_w[g])
			);
		end
	endgenerate

	// Lookup, miss handling and block fill
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q    <= S_CLR;
			clr_q      <= 9'h000;
			addr_q     <= 20'h00000;
			cnt_q      <= 2'h0;
			victim_q   <= 1'b0;
			fifo_q     <= {SETS{1'b0}};
			lru_q      <= {SETS{1'b0}};
			lfsr_q     <= 8'h01;
			crit_q     <= 8'h00;
			hit_o      <= 1'b0;
			miss_o     <= 1'b0;
			wait_o     <= 1'b0;
			ack_o      <= 1'b0;
			rdata_o    <= 8'h00;
			mem_req_o  <= 1'b0;
			mem_addr_o <= 20'h00000;
			ready_o    <= 1'b0;
		end
		else
		begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			hit_o  <= 1'b0;
			miss_o <= 1'b0;
			ack_o  <= 1'b0;
			case (state_q)
			S_CLR:
			begin
				clr_q <= clr_q + 9'h001;
				if (clr_q == SETS - 1)
				begin
					state_q <= S_IDLE;
					ready_o <= 1'b1;
				end
			end
			S_IDLE:
			begin
				if (req_i && any_hit)
				begin
					hit_o   <= 1'b1;
					ack_o   <= 1'b1;
					rdata_o <= hit_way ? dat_w[1] : dat_w[0];
					lru_q[set] <= hit_way;
				end
				else if (req_i)
				begin
					miss_o     <= 1'b1;
					wait_o     <= 1'b1;
					addr_q     <= addr_i;
					mem_req_o  <= 1'b1;
					mem_addr_o <= {addr_i[`ADDR_W-1:`WORD_W], 2'h0};
					cnt_q      <= 2'h0;
					victim_q   <= pick(policy_i, fifo_q[set],
						lru_q[set], lfsr_q[0]);
					state_q    <= S_FILL;
				end
			end
			S_FILL:
			begin
				// Memory pace comes from mem_ack_i alone
				if (mem_ack_i)
				begin
					if (cnt_q == addr_q[`WORD_W-1:0])
						crit_q <= mem_data_i;
					cnt_q      <= cnt_q + 2'h1;
					mem_addr_o <= {addr_q[`ADDR_W-1:`WORD_W], cnt_q + 2'h1};
					if (cnt_q == 2'h3)
					begin
						mem_req_o     <= 1'b0;
						wait_o        <= 1'b0;
						ack_o         <= 1'b1;
						rdata_o       <= (addr_q[1:0] == 2'h3) ?
							mem_data_i : crit_q;
						fifo_q[aset]  <= ~victim_q;
						lru_q[aset]   <= victim_q;
						state_q       <= S_IDLE;
					end
				end
			end
			default:
				state_q <= S_CLR;
			endcase
		end
	end
endmodule // cache_tag_lookup

// ---- cache_tag_lookup_assertions.sv ----
// Port checker for the cache tag lookup
`timescale 1ns/100ps
`include "cache_tag_regs.vh"
module cache_tag_lookup_assertions
(
	input wire			clk_i,
	input wire			arst_n_i,
	input wire			req_i,
	input wire [`ADDR_W-1:0]	addr_i,
	input wire			mem_ack_i,
	input wire			hit_o,
	input wire			miss_o,
	input wire			wait_o,
	input wire			ack_o,
	input wire			mem_req_o,
	input wire [`ADDR_W-1:0]	mem_addr_o,
	input wire			ready_o
);
	reg [2:0]	n_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Words fetched since the last miss
	always @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i) n_q <= 3'h0;
		else if (miss_o) n_q <= 3'h0;
		else if (mem_req_o && mem_ack_i) n_q <= n_q + 3'h1;
	sequence s_take;
		req_i && ready_o && !wait_o;
	endsequence
	property p_ans; s_take |=> hit_o ^ miss_o; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_hack; hit_o |-> ack_o && !wait_o; endproperty
	a_hack: assert property (p_hack) else $error("hit slow");
	property p_miss; miss_o |-> wait_o && mem_req_o && !ack_o; endproperty
	a_miss: assert property (p_miss) else $error("miss");
	property p_done; ack_o && !hit_o |-> $fell(wait_o); endproperty
	a_done: assert property (p_done) else $error("hold");
	property p_rdy; !ready_o |-> !(hit_o || miss_o || mem_req_o); endproperty
	a_rdy: assert property (p_rdy) else $error("early");
	property p_blk; $fell(mem_req_o) |-> n_q == 3'h4; endproperty
	a_blk: assert property (p_blk) else $error("part block");
	property p_inc; mem_req_o && mem_ack_i |=> !mem_req_o ||
		mem_addr_o[1:0] == $past(mem_addr_o[1:0]) + 2'h1; endproperty
	a_inc: assert property (p_inc) else $error("word step");
	property p_set; $rose(mem_req_o) |-> mem_addr_o[1:0] == 2'h0 &&
		mem_addr_o[10:2] == $past(addr_i[10:2]); endproperty
	a_set: assert property (p_set) else $error("set");
endmodule // cache_tag_lookup_assertions
bind cache_tag_lookup cache_tag_lookup_assertions u_chk(.clk_i, .arst_n_i,
	.req_i, .addr_i, .mem_ack_i, .hit_o, .miss_o, .wait_o, .ack_o,
	.mem_req_o, .mem_addr_o, .ready_o);

// ---- mem_model.sv ----
// Slow main memory answering block fetches
`timescale 1ns/100ps
`include "cache_tag_regs.vh"
module mem_model
(
	input wire			clk_i,
	input wire			req_i,
	input wire [`ADDR_W-1:0]	addr_i,
	input wire [1:0]		steps_i,
	output reg			ack_o = 1'b0,
	output reg [7:0]		data_o = 8'h00
);
	integer	c = 0;
	// One word per wait span; data toggles on every cycle without an ack
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		data_o <= ~data_o;
		if (req_i && !ack_o)
		begin
			c = c + 1;
			if (c > steps_i * `STEP_CYC)
			begin
				c = 0;
				ack_o <= 1'b1;
				data_o <= addr_i[7:0] ^ 8'h5a;
			end
		end
		else c = 0;
	end
endmodule // mem_model

// ---- cache_tag_lookup_tb.sv ----
// Self-checking bench for the cache tag lookup
`timescale 1ns/100ps
`include "cache_tag_regs.vh"
module cache_tag_lookup_tb;
	reg			clk_i = 0, arst_n_i = 0, req_i = 0;
	reg [`ADDR_W-1:0]	addr_i = 0;
	reg [1:0]		policy_i = 0, steps = 0;
	wire			mem_ack_i, hit_o, miss_o, wait_o, ack_o;
	wire			mem_req_o, ready_o;
	wire [7:0]		mem_data_i, rdata_o;
	wire [`ADDR_W-1:0]	mem_addr_o;
	integer			n_errors = 0, total_checks = 0, i;
	cache_tag_lookup dut(.clk_i, .arst_n_i, .req_i, .addr_i, .policy_i,
		.mem_ack_i, .mem_data_i, .hit_o, .miss_o, .wait_o, .ack_o,
		.rdata_o, .mem_req_o, .mem_addr_o, .ready_o);
	mem_model mm(.clk_i, .req_i(mem_req_o), .addr_i(mem_addr_o),
		.steps_i(steps), .ack_o(mem_ack_i), .data_o(mem_data_i));
	always #12.5 clk_i = ~clk_i;
	task wrap_up;
	begin
		if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end
	endtask
	task chk(input [23:0] nm, input [7:0] s, input [7:0] e);
	begin
		total_checks = total_checks + 1;
		if (s !== e)
		begin
			n_errors = n_errors + 1;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	end
	endtask
	// One access, e set when a hit is expected
	task acc(input [`ADDR_W-1:0] a, input e);
		integer k;
	begin
		req_i = 1;
		addr_i = a;
		@(posedge clk_i) #1 req_i = 0;
		chk("ack", ack_o, e);
		chk("wt", wait_o, !e);
		chk("mis", miss_o, !e);
		chk("mrq", mem_req_o, !e);
		if (!e) chk("mad", mem_addr_o[7:0], a[7:0] & 8'hfc);
		for (k = 0; k < 300 && ack_o !== 1; k = k + 1) @(posedge clk_i) #1;
		chk("hit", hit_o, e);
		chk("dat", rdata_o, a[7:0] ^ 8'h5a);
		@(posedge clk_i) #1;
	end
	endtask
	task t_reset;
	begin
		for (i = 0; i < 600 && ready_o !== 1; i = i + 1) @(posedge clk_i) #1;
		chk("rdy", ready_o, 1'b1);
		acc(20'h00000, 0);
		acc(20'h00001, 1);
	end
	endtask
	task t_block;
	begin
		acc(20'h12346, 0);
		for (i = 0; i < 4; i = i + 1) acc({18'h048d1, i[1:0]}, 1);
		acc(20'h12348, 0);
	end
	endtask
	task t_ways;
	begin
		acc(20'h13344, 0);
		acc(20'h12345, 1);
		for (i = 0; i < 3; i = i + 1)
		begin
			policy_i = i[1:0];
			acc({i[7:0], 12'h344}, 0);
			acc({i[7:0], 12'h347}, 1);
		end
	end
	endtask
	task t_slow;
	begin
		steps = 2;
		acc(20'h55552, 0);
		steps = 0;
		acc(20'h55553, 1);
	end
	endtask
	initial
	begin
		repeat (4) @(posedge clk_i);
		#1 arst_n_i = 1;
		t_reset;
		t_block;
		t_ways;
		t_slow;
		wrap_up;
	end
	initial
	begin
		#500000 n_errors = n_errors + 1;
		wrap_up;
	end
endmodule // cache_tag_lookup_tb
